// *** rtl/burst_sram_pkg.sv ***
// constants shared by the burst sram port control and its storage array
// assumes one beat clock: alternate edges stand for the true and complementary clock rises
// Notes on behaviour
// - a write starts when the write select is low at a true clock rise, latching the address.
// - the four write words are captured at the true and complementary rises of cycles t+1 and t+2.
// - a read latched at a true rise drives its words at the rises of cycles t+2 and t+3.
// - each burst moves four words, the latched address first and then the next three in order.
// - a second read or a second write on the next true rise is discarded.
// - a select that started an operation on the last true rise is ignored on the next one.
// - after reset both ports are idle and the read data outputs are not driven.
// - byte write selects are sampled with every write beat and may change from beat to beat.
// - in the 18-bit width, select 0 writes bits 8:0 and select 1 bits 17:9, others are kept.
// - in the 36-bit width, selects 0 to 3 write bits 8:0, 17:9, 26:18 and 35:27 of each beat.
// - a write beat with all byte selects high leaves memory unchanged, the burst goes on.
// - both port selects are sampled only at true clock rises.
// - with both selected after an idle cycle the read goes first, then reads and writes alternate.
`default_nettype none
package burst_sram_pkg;
	localparam int         WORD_W_DEFAULT = 18; // 18 or 36
	localparam int         ADDR_W_DEFAULT = 19; // burst locations of the 18-bit part
	localparam int         BYTE_W         = 9;
	localparam int         BEAT_W         = 2;  // four beats per burst
	localparam logic [1:0] FIRST_BEAT     = 2'h0;
	localparam logic [1:0] LAST_BEAT      = 2'h3;
	localparam logic [1:0] BEAT_STEP      = 2'h1;
	localparam logic [1:0] RD_WAIT        = 2'h2; // read wait count; array access comes four beats after read start
	localparam logic [1:0] WR_WAIT        = 2'h0; // write wait count; first capture comes two beats after write start
	localparam logic       PHASE_TRUE     = 1'b0; // phase of a true clock rise
endpackage
`default_nettype wire

// *** rtl/burst_sram_mem.sv ***
// storage array with one byte-masked write port and one registered read port
// assumes the caller keeps addresses in range; no read-during-write forwarding
`timescale 1ns/1ps
`default_nettype none
module burst_sram_mem #(
	parameter int WORD_W = 18,
	parameter int LANES  = 2,
	parameter int AW     = 21
) (
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              resetn_i,
	// write port
	input  wire logic [LANES-1:0]  lane_we_i,
	input  wire logic [AW-1:0]     wr_addr_i,
	input  wire logic [WORD_W-1:0] wr_data_i,
	// read port
	input  wire logic              rd_en_i,
	input  wire logic [AW-1:0]     rd_addr_i,
	output logic      [WORD_W-1:0] rd_data_o
);
	logic [WORD_W-1:0] mem [0:(1<<AW)-1];

	// byte lanes written alone; a lane left out keeps its old bits
	always_ff @(posedge clock_i)
	begin
		for (int l = 0; l < LANES; l++)
		begin
			if (lane_we_i[l])
				mem[wr_addr_i][l*burst_sram_pkg::BYTE_W +: burst_sram_pkg::BYTE_W] <=
					wr_data_i[l*burst_sram_pkg::BYTE_W +: burst_sram_pkg::BYTE_W];
		end
	end

	// read data held in a register so it can feed a pin directly
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rd_data_o <= '0;
		else if (rd_en_i)
			rd_data_o <= mem[rd_addr_i];
	end
endmodule // burst_sram_mem
`default_nettype wire

// *** rtl/ddr_burst_sram_port_control.sv ***
// command and data-phase control of a burst sram with separate read and write ports
// assumes clock_i runs at the beat rate; controller signals come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module ddr_burst_sram_port_control #(
	parameter int WORD_W = burst_sram_pkg::WORD_W_DEFAULT,
	parameter int ADDR_W = burst_sram_pkg::ADDR_W_DEFAULT
) (
	// clock and reset
	input  wire logic                             clock_i,
	input  wire logic                             resetn_i,
	// low while the controller holds the clocks stopped
	input  wire logic                             clock_run_i,
	// command
	input  wire logic                             read_port_select_n_i,
	input  wire logic                             write_port_select_n_i,
	input  wire logic [ADDR_W-1:0]                addr_i,
	// write data
	input  wire logic [WORD_W-1:0]                d_i,
	input  wire logic [WORD_W/burst_sram_pkg::BYTE_W-1:0] byte_write_select_n_i,
	// read data
	output logic      [WORD_W-1:0]                q_o,
	output logic                                  q_oe_o
);
	localparam int LANES = WORD_W / burst_sram_pkg::BYTE_W;
	localparam int AW    = ADDR_W + burst_sram_pkg::BEAT_W;

	logic              phase_reg;
	logic              last_read_reg;
	logic              last_write_reg;
	logic              rd_pend_reg;
	logic [1:0]        rd_wait_reg;
	logic [ADDR_W-1:0] rd_paddr_reg;
	logic              rd_busy_reg;
	logic [1:0]        rd_beat_reg;
	logic [ADDR_W-1:0] rd_addr_reg;
	logic              wr_pend_reg;
	logic [1:0]        wr_wait_reg;
	logic [ADDR_W-1:0] wr_paddr_reg;
	logic              wr_busy_reg;
	logic [1:0]        wr_beat_reg;
	logic [ADDR_W-1:0] wr_addr_reg;
	logic              q_oe_reg;

	// command decode, only on true rises
	wire k_rise      = clock_run_i && (phase_reg == burst_sram_pkg::PHASE_TRUE);
	wire read_ok     = !read_port_select_n_i && !last_read_reg;
	wire write_ok    = !write_port_select_n_i && !last_write_reg;
	wire start_read  = k_rise && read_ok;
	wire start_write = k_rise && write_ok && !read_ok;
	wire rd_load     = clock_run_i && rd_pend_reg && (rd_wait_reg == '0);
	wire wr_load     = clock_run_i && wr_pend_reg && (wr_wait_reg == '0);
	wire rd_en       = clock_run_i && rd_busy_reg;
	wire wr_en       = clock_run_i && wr_busy_reg;
	// burst word address: latched location, then beat offset
	wire [AW-1:0]    rd_word = {rd_addr_reg, rd_beat_reg};
	wire [AW-1:0]    wr_word = {wr_addr_reg, wr_beat_reg};
	wire [LANES-1:0] lane_we = {LANES{wr_en}} & ~byte_write_select_n_i;

	// beat phase and previous-rise history; a stopped clock freezes all of it
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			phase_reg      <= burst_sram_pkg::PHASE_TRUE;
			last_read_reg  <= 1'b0;
			last_write_reg <= 1'b0;
		end
		else if (clock_run_i)
		begin
			phase_reg <= ~phase_reg;
			if (k_rise)
			begin
				last_read_reg  <= start_read;
				last_write_reg <= start_write;
			end
		end
	end

	// read latency wait; next read cannot arrive before this one is handed on
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rd_pend_reg  <= 1'b0;
			rd_wait_reg  <= '0;
			rd_paddr_reg <= '0;
		end
		else if (start_read)
		begin
			rd_pend_reg  <= 1'b1;
			rd_wait_reg  <= burst_sram_pkg::RD_WAIT;
			rd_paddr_reg <= addr_i;
		end
		else if (rd_load)
			rd_pend_reg <= 1'b0;
		else if (clock_run_i && rd_pend_reg)
			rd_wait_reg <= rd_wait_reg - burst_sram_pkg::BEAT_STEP;
	end

	// read burst engine: four array reads in address order
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rd_busy_reg <= 1'b0;
			rd_beat_reg <= burst_sram_pkg::FIRST_BEAT;
			rd_addr_reg <= '0;
		end
		else if (rd_load)
		begin
			rd_busy_reg <= 1'b1;
			rd_beat_reg <= burst_sram_pkg::FIRST_BEAT;
			rd_addr_reg <= rd_paddr_reg;
		end
		else if (rd_en)
		begin
			rd_busy_reg <= (rd_beat_reg != burst_sram_pkg::LAST_BEAT);
			rd_beat_reg <= rd_beat_reg + burst_sram_pkg::BEAT_STEP;
		end
	end

	// write address hold until the first data beat
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wr_pend_reg  <= 1'b0;
			wr_wait_reg  <= '0;
			wr_paddr_reg <= '0;
		end
		else if (start_write)
		begin
			wr_pend_reg  <= 1'b1;
			wr_wait_reg  <= burst_sram_pkg::WR_WAIT;
			wr_paddr_reg <= addr_i;
		end
		else if (wr_load)
			wr_pend_reg <= 1'b0;
		else if (clock_run_i && wr_pend_reg)
			wr_wait_reg <= wr_wait_reg - burst_sram_pkg::BEAT_STEP;
	end

	// write burst engine: each beat goes straight into the array
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wr_busy_reg <= 1'b0;
			wr_beat_reg <= burst_sram_pkg::FIRST_BEAT;
			wr_addr_reg <= '0;
		end
		else if (wr_load)
		begin
			wr_busy_reg <= 1'b1;
			wr_beat_reg <= burst_sram_pkg::FIRST_BEAT;
			wr_addr_reg <= wr_paddr_reg;
		end
		else if (wr_en)
		begin
			wr_busy_reg <= (wr_beat_reg != burst_sram_pkg::LAST_BEAT);
			wr_beat_reg <= wr_beat_reg + burst_sram_pkg::BEAT_STEP;
		end
	end

	// output enable registered on the same edge as the array read and held while the clock is stopped, floats otherwise
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			q_oe_reg <= 1'b0;
		else if (clock_run_i)
			q_oe_reg <= rd_en;
	end

	assign q_oe_o = q_oe_reg;

	// storage; q_o is its read register
	burst_sram_mem #(
		.WORD_W (WORD_W),
		.LANES  (LANES),
		.AW     (AW)
	) u_mem (
		.clock_i   (clock_i),
		.resetn_i  (resetn_i),
		.lane_we_i (lane_we),
		.wr_addr_i (wr_word),
		.wr_data_i (d_i),
		.rd_en_i   (rd_en),
		.rd_addr_i (rd_word),
		.rd_data_o (q_o)
	);

	// checks assume the clocks keep running; a stop disables only the first four of them
	property p_write_beats;
		@(posedge clock_i) disable iff (!resetn_i || !clock_run_i)
		start_write |-> ##2 wr_busy_reg [*4];
	endproperty
	a_write_beats: assert property (p_write_beats) else $error("write beats misplaced");

	property p_read_latency;
		@(posedge clock_i) disable iff (!resetn_i || !clock_run_i)
		start_read |-> !rd_pend_reg ##5 q_oe_o [*4];
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("read data misplaced");

	property p_burst_order;
		@(posedge clock_i) disable iff (!resetn_i || !clock_run_i)
		(rd_busy_reg && rd_beat_reg == burst_sram_pkg::FIRST_BEAT) |=>
			rd_beat_reg == 2'h1 ##1 rd_beat_reg == 2'h2 ##1 rd_beat_reg == 2'h3;
	endproperty
	a_burst_order: assert property (p_burst_order) else $error("burst order wrong");

	property p_no_back_to_back;
		@(posedge clock_i) disable iff (!resetn_i || !clock_run_i)
		(start_read || start_write) |-> ##2 !(start_read && $past(start_read, 2))
			&& !(start_write && $past(start_write, 2));
	endproperty
	a_no_back_to_back: assert property (p_no_back_to_back) else $error("second request taken");

	property p_select_dont_care;
		@(posedge clock_i) disable iff (!resetn_i)
		(k_rise && last_read_reg) |-> !start_read;
	endproperty
	a_select_dont_care: assert property (p_select_dont_care) else $error("repeat read started");

	property p_nop;
		@(posedge clock_i) disable iff (!resetn_i)
		(read_port_select_n_i && write_port_select_n_i) |-> !start_read && !start_write;
	endproperty
	a_nop: assert property (p_nop) else $error("operation without select");

	property p_oe_only_reading;
		@(posedge clock_i) disable iff (!resetn_i)
		q_oe_o |-> $past(rd_busy_reg);
	endproperty
	a_oe_only_reading: assert property (p_oe_only_reading) else $error("output driven idle");

	property p_masked_beat;
		@(posedge clock_i) disable iff (!resetn_i)
		(&byte_write_select_n_i || !wr_busy_reg) |-> (lane_we == '0);
	endproperty
	a_masked_beat: assert property (p_masked_beat) else $error("masked lane written");

	property p_true_rise_only;
		@(posedge clock_i) disable iff (!resetn_i)
		(phase_reg != burst_sram_pkg::PHASE_TRUE) |-> !start_read && !start_write;
	endproperty
	a_true_rise_only: assert property (p_true_rise_only) else $error("select taken off phase");

	property p_read_first;
		@(posedge clock_i) disable iff (!resetn_i)
		(k_rise && read_ok && write_ok) |-> start_read && !start_write ##2 !start_read;
	endproperty
	a_read_first: assert property (p_read_first) else $error("arbitration wrong");
endmodule // ddr_burst_sram_port_control
`default_nettype wire

// *** testbench/ctrl_model.sv ***
// partner: controller side issuing selects, addresses and write beats
// assumes the first edge after reset release is a true-clock rise
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
	// clock and reset
	input  wire logic   clock_i,
	input  wire logic   resetn_i,
	// command and write beats
	output logic        run_o,
	output logic        rd_n_o,
	output logic        wr_n_o,
	output logic [3:0]  addr_o,
	output logic [17:0] d_o,
	output logic [1:0]  bws_n_o
);
	logic [15:0] beat;

	// beat index frozen with the clock, even = true rise
	always @(posedge clock_i or negedge resetn_i)
		if (!resetn_i)
			beat <= 16'h0000;
		else if (run_o)
			beat <= beat + 16'h0001;

	// idle: both ports deselected
	initial
	begin
		{run_o, rd_n_o, wr_n_o, bws_n_o} = 5'h1F;
		addr_o = 4'h0;
		d_o = 18'h00000;
	end

	// hold above 2 repeats a request on purpose
	task automatic cmd(input logic rn, input logic wn, input logic [3:0] a, input int hold);
		do @(posedge clock_i); while (beat[0] == 1'b0);
		rd_n_o <= rn;
		wr_n_o <= wn;
		addr_o <= a;
		repeat (hold) @(posedge clock_i);
		rd_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		addr_o <= ~a; // released bus must not keep the last value
	endtask

	// four beats, masks may change per beat
	task automatic wdata(input logic [71:0] dv, input logic [7:0] mk);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clock_i);
			d_o <= dv[18*i +: 18];
			bws_n_o <= mk[2*i +: 2];
		end
		@(posedge clock_i);
		d_o <= ~d_o;
		bws_n_o <= 2'h3;
	endtask

	// clocks held stopped for n beats
	task automatic stop(input int n);
		run_o <= 1'b0;
		repeat (n) @(posedge clock_i);
		run_o <= 1'b1;
	endtask
endmodule // ctrl_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the burst sram port control, 18-bit width
// assumes the partner model drives every command and write input
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        run, rd_n, wr_n, q_oe_o;
	logic [3:0]  addr;
	logic [17:0] d, q_o;
	logic [1:0]  bws_n;
	logic [17:0] mem [64];
	int          bad_count = 0;
	int          compares = 0;

	// 10 MHz
	always #50 clock_i = ~clock_i;

	ctrl_model i_ctrl (.clock_i(clock_i), .resetn_i(resetn_i), .run_o(run), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .addr_o(addr), .d_o(d), .bws_n_o(bws_n));

	ddr_burst_sram_port_control #(.WORD_W(18), .ADDR_W(4)) i_dut (
		.clock_i(clock_i), .resetn_i(resetn_i), .clock_run_i(run),
		.read_port_select_n_i(rd_n), .write_port_select_n_i(wr_n), .addr_i(addr),
		.d_i(d), .byte_write_select_n_i(bws_n), .q_o(q_o), .q_oe_o(q_oe_o));

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// reference contents, per lane
	task automatic upd(input logic [3:0] a, input logic [71:0] dv, input logic [7:0] mk);
		for (int i = 0; i < 8; i++)
			if (!mk[i])
				mem[{a, 2'(i / 2)}][9*(i%2) +: 9] = dv[9*i +: 9];
	endtask

	task automatic wr(input logic [3:0] a, input logic [71:0] dv, input logic [7:0] mk);
		i_ctrl.cmd(1'b1, 1'b0, a, 1);
		i_ctrl.wdata(dv, mk);
		upd(a, dv, mk);
	endtask

	// expectation taken at entry, before any overlapping write lands
	task automatic collect(input logic [3:0] a, input int lead);
		logic [71:0] e;
		for (int i = 0; i < 4; i++)
			e[18*i +: 18] = mem[{a, 2'(i)}];
		repeat (lead) @(posedge clock_i);
		for (int i = 0; i < 4; i++)
		begin
			@(negedge clock_i);
			check({17'h00000, q_oe_o, q_o}, {18'h00001, e[18*i +: 18]});
		end
		@(negedge clock_i);
		check({35'h0, q_oe_o}, 36'h0);
	endtask

	task automatic t_burst;
		wr(4'h3, 72'h123456789ABCDEF012, 8'h00);
		i_ctrl.cmd(1'b0, 1'b1, 4'h3, 1);
		collect(4'h3, 4);
		$display("burst done");
	endtask

	// lane 0, lane 1, no lane, both lanes
	task automatic t_mask;
		wr(4'h5, 72'hFEDCBA987654321FED, 8'h00);
		wr(4'h5, 72'h0F1E2D3C4B5A697887, 8'h36);
		i_ctrl.cmd(1'b0, 1'b1, 4'h5, 1);
		collect(4'h5, 4);
		$display("mask done");
	endtask

	// read held over two true rises: one burst only
	task automatic t_b2b;
		i_ctrl.cmd(1'b0, 1'b1, 4'h3, 4);
		collect(4'h3, 1);
		$display("b2b done");
	endtask

	// both selected from idle: read first, write one true rise later
	task automatic t_both;
		i_ctrl.cmd(1'b0, 1'b0, 4'h5, 3);
		fork
			i_ctrl.wdata(72'h2468ACE13579BDF024, 8'h00);
			collect(4'h5, 2);
		join
		upd(4'h5, 72'h2468ACE13579BDF024, 8'h00);
		i_ctrl.cmd(1'b0, 1'b1, 4'h5, 1);
		collect(4'h5, 4);
		$display("both done");
	endtask

	task automatic t_standby;
		i_ctrl.cmd(1'b0, 1'b1, 4'h3, 1);
		i_ctrl.stop(3);
		collect(4'h3, 4);
		// stop in the data phase: first word must still stand afterwards
		i_ctrl.cmd(1'b0, 1'b1, 4'h5, 1);
		repeat (4) @(posedge clock_i);
		i_ctrl.stop(3);
		collect(4'h5, 0);
		$display("standby done");
	endtask

	// reset in mid-burst: output floats at once and stays idle after release
	task automatic t_reset;
		i_ctrl.cmd(1'b0, 1'b1, 4'h3, 1);
		repeat (5) @(posedge clock_i);
		resetn_i <= 1'b0;
		@(negedge clock_i);
		check({35'h0, q_oe_o}, 36'h0);
		@(posedge clock_i);
		resetn_i <= 1'b1;
		repeat (2) @(negedge clock_i);
		check({35'h0, q_oe_o}, 36'h0);
		i_ctrl.cmd(1'b0, 1'b1, 4'h3, 1);
		collect(4'h3, 4);
		$display("reset done");
	endtask

	initial
	begin
		repeat (8) @(posedge clock_i);
		check({35'h0, q_oe_o}, 36'h0);
		resetn_i <= 1'b1;
		t_burst();
		t_mask();
		t_b2b();
		t_both();
		t_standby();
		t_reset();
		finish_test();
	end

	// tests need about 150 cycles, ten thousand is a hang
	initial
	begin
		#1000000;
		bad_count++;
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
